/* File: src/pfd_pkg.sv */
package pfd_pkg;
	localparam int PFD_PORTS = 4;
	localparam int PFD_CHANS = 4;
	localparam int PFD_EGR_CHANS = 2;
	localparam int PFD_DATA_W = 64;
	localparam int PFD_CH_W = 2;
	localparam int PFD_HDR_BYTES = 32;
	localparam int PFD_HDR_UNIT_BIT = 0;
	localparam int PFD_MAX_LAG_40G = 4;
	localparam int PFD_MAX_LAG_10G = 8;
	localparam int PFD_HALVES = 2;
	localparam logic [31:0] PFD_HASH_SEED = 32'h811C9DC5;
	localparam logic [31:0] PFD_HASH_MULT = 32'h01000193;
	// hash input choices; reset value is the ip pair
	typedef enum logic [2:0] {
		PFD_HSEL_IP_PAIR,
		PFD_HSEL_SRC_IP,
		PFD_HSEL_DST_IP,
		PFD_HSEL_MAC_PAIR,
		PFD_HSEL_L4_PAIR,
		PFD_HSEL_FULL
	} pfd_hsel_type;
	localparam pfd_hsel_type PFD_HSEL_RESET = PFD_HSEL_IP_PAIR;
	typedef struct packed {
		logic [47:0] srcMac;
		logic [47:0] dstMac;
		logic [31:0] srcIp;
		logic [31:0] dstIp;
		logic [15:0] srcL4;
		logic [15:0] dstL4;
		logic [7:0] proto;
	} pfd_flow_key_type;
	typedef struct packed {
		logic valid;
		logic sof;
		logic eof;
		logic [63:0] data;
		pfd_flow_key_type key;
	} pfd_ing_beat_type;
	typedef struct packed {
		logic valid;
		logic sof;
		logic eof;
		logic [63:0] data;
		logic [1:0] destPort;
		logic unitSel;
	} pfd_egr_beat_type;
endpackage : pfd_pkg

/* File: src/pfd_port_flow_distributor.sv */
module pfd_port_flow_distributor
	import pfd_pkg::*;
#(
	parameter int LAG_COUNT_W = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [PFD_HALVES-1:0] halfIs10g,
	input wire pfd_hsel_type [PFD_PORTS-1:0] hashSel,
	input wire logic macsecEnable,
	input wire pfd_ing_beat_type [PFD_PORTS-1:0] ingIn,
	input wire pfd_egr_beat_type [PFD_EGR_CHANS-1:0] egrIn,
	input wire logic [LAG_COUNT_W-1:0] lagMembers,
	input wire logic lagIsFortyG,
	output pfd_ing_beat_type [PFD_CHANS-1:0] ingChan,
	output pfd_egr_beat_type [PFD_PORTS-1:0] egrPort,
	output logic [PFD_EGR_CHANS-1:0] egrReady,
	output logic [PFD_PORTS-1:0] cryptApplied,
	output logic unitOut,
	output logic lagAccept
);
	initial begin
		if (PFD_PORTS != PFD_CHANS || LAG_COUNT_W < 4) begin
			$error("pfd: port/channel count or lag width unsupported");
		end
	end

	// fnv style fold over the selected key fields
	function automatic logic [31:0] keyHash(input pfd_flow_key_type k, input pfd_hsel_type s);
		logic [31:0] h;
		logic [191:0] f;
		h = PFD_HASH_SEED;
		unique case (s)
			PFD_HSEL_IP_PAIR: f = {128'h0, k.srcIp, k.dstIp};
			PFD_HSEL_SRC_IP: f = {160'h0, k.srcIp};
			PFD_HSEL_DST_IP: f = {160'h0, k.dstIp};
			PFD_HSEL_MAC_PAIR: f = {96'h0, k.srcMac, k.dstMac};
			PFD_HSEL_L4_PAIR: f = {88'h0, k.srcIp, k.dstIp, k.srcL4, k.dstL4, k.proto};
			default: f = {k.srcMac[31:0], k.dstMac[31:0], k.srcIp, k.dstIp, k.srcL4, k.dstL4,
				k.proto, 8'h00, k.srcMac[47:32] ^ k.dstMac[47:32]};
		endcase
		for (int i = 0; i < 6; i++) begin
			h = (h ^ f[i*32 +: 32]) * PFD_HASH_MULT;
		end
		return h;
	endfunction : keyHash

	function automatic logic portIs10g(input logic [PFD_HALVES-1:0] m, input int p);
		return m[p / (PFD_PORTS / PFD_HALVES)];
	endfunction : portIs10g

	// low hash bits pick the channel; same key and selection always give the same channel
	function automatic logic [PFD_CH_W-1:0] hashChan(input pfd_flow_key_type k,
			input pfd_hsel_type s);
		logic [31:0] h;
		h = keyHash(k, s);
		return h[PFD_CH_W-1:0];
	endfunction : hashChan

	// selection register comes up on the ip pair until a port loads its own choice
	pfd_hsel_type [PFD_PORTS-1:0] activeSel;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int p = 0; p < PFD_PORTS; p++) begin
				activeSel[p] <= PFD_HSEL_RESET;
			end
		end else begin
			activeSel <= hashSel;
		end
	end

	// ingress: per port channel latched at start of frame so a frame never splits
	logic [PFD_CH_W-1:0] frameChan [PFD_PORTS];
	logic [PFD_CH_W-1:0] next_chan [PFD_PORTS];
	logic [PFD_CHANS-1:0] busy;
	logic [PFD_PORTS-1:0] inFrame;
	pfd_ing_beat_type [PFD_CHANS-1:0] next_ingChan;

	always_comb begin
		for (int p = 0; p < PFD_PORTS; p++) begin
			if (portIs10g(halfIs10g, p)) begin
				next_chan[p] = PFD_CH_W'(p);
			end else if (ingIn[p].sof) begin
				next_chan[p] = hashChan(ingIn[p].key, activeSel[p]);
			end else begin
				next_chan[p] = frameChan[p];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			inFrame <= '0;
			for (int p = 0; p < PFD_PORTS; p++) begin
				frameChan[p] <= '0;
			end
		end else begin
			for (int p = 0; p < PFD_PORTS; p++) begin
				if (ingIn[p].valid) begin
					frameChan[p] <= next_chan[p];
					inFrame[p] <= !ingIn[p].eof;
				end
			end
		end
	end

	// fixed priority per channel; port stream arrives already reassembled
	always_comb begin
		next_ingChan = '0;
		busy = '0;
		for (int p = 0; p < PFD_PORTS; p++) begin
			if (ingIn[p].valid && !busy[next_chan[p]]) begin
				busy[next_chan[p]] = 1'b1;
				next_ingChan[next_chan[p]] = ingIn[p];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ingChan <= '0;
		end else begin
			ingChan <= next_ingChan;
		end
	end

	// egress: the registered grant names the engine whose beat is taken this cycle,
	// so an engine that sees its ready high knows its beat went, and none is taken twice
	logic ownerLocked;
	logic pick;
	pfd_egr_beat_type cur;
	always_comb begin
		pick = egrReady[1];
		cur = egrIn[pick];
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ownerLocked <= 1'b0;
		end else if (cur.valid) begin
			ownerLocked <= !cur.eof;
		end
	end

	// grant moves on at end of frame, or on each idle cycle outside a frame
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			egrReady <= '0;
			egrReady[0] <= 1'b1;
		end else if (cur.valid ? cur.eof : !ownerLocked) begin
			egrReady <= {egrReady[0], egrReady[1]};
		end
	end

	// 40G: whole half gets the merged frame on its first port; 10G: port by mapping
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			egrPort <= '0;
			unitOut <= 1'b0;
		end else begin
			egrPort <= '0;
			if (cur.valid) begin
				unitOut <= cur.unitSel;
				if (portIs10g(halfIs10g, int'(cur.destPort))) begin
					egrPort[cur.destPort] <= cur;
				end else begin
					egrPort[{cur.destPort[1], 1'b0}] <= cur;
				end
			end
		end
	end

	// protection status per port path
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cryptApplied <= '0;
		end else begin
			for (int p = 0; p < PFD_PORTS; p++) begin
				cryptApplied[p] <= macsecEnable && (ingIn[p].valid || inFrame[p]);
			end
		end
	end

	// aggregation membership check
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lagAccept <= 1'b0;
		end else if (lagIsFortyG) begin
			lagAccept <= lagMembers != '0 && lagMembers <= LAG_COUNT_W'(PFD_MAX_LAG_40G);
		end else begin
			lagAccept <= lagMembers != '0 && lagMembers <= LAG_COUNT_W'(PFD_MAX_LAG_10G);
		end
	end

	a_tenG_mapping: assert property (@(posedge sys_clk) disable iff (rst)
		(ingIn[0].valid && halfIs10g[0]) |=> ingChan[0].valid)
		else $error("10G port 0 not on channel 0");
	a_lag_limit: assert property (@(posedge sys_clk) disable iff (rst)
		(lagIsFortyG && lagMembers > LAG_COUNT_W'(PFD_MAX_LAG_40G)) |=> !lagAccept)
		else $error("40G group over four accepted");
	a_lag_ten: assert property (@(posedge sys_clk) disable iff (rst)
		(!lagIsFortyG && lagMembers == LAG_COUNT_W'(PFD_MAX_LAG_10G)) |=> lagAccept)
		else $error("10G group of eight refused");
	a_crypt_off: assert property (@(posedge sys_clk) disable iff (rst)
		!macsecEnable |=> cryptApplied == '0)
		else $error("crypto applied while disabled");
	a_frame_owner: assert property (@(posedge sys_clk) disable iff (rst)
		(cur.valid && !cur.eof) |=> pick == $past(pick))
		else $error("egress merge switched mid frame");
	a_unit_follow: assert property (@(posedge sys_clk) disable iff (rst)
		cur.valid |=> unitOut == $past(cur.unitSel))
		else $error("unit select not followed");
	a_ready_one: assert property (@(posedge sys_clk) disable iff (rst)
		##1 $onehot(egrReady))
		else $error("merger ready not one hot");
	a_chan_stable: assert property (@(posedge sys_clk) disable iff (rst)
		(ingIn[1].valid && !ingIn[1].sof && !halfIs10g[0]) |-> next_chan[1] == frameChan[1])
		else $error("channel changed inside frame");

	// ingress checks
	a_ten_one: assert property (@(posedge sys_clk) disable iff (rst)
		(ingIn[1].valid && halfIs10g[0]) |=> ingChan[1].valid && ingChan[1].data == $past(ingIn[1].data))
		else $error("10G port 1 not on channel 1");
	a_ten_two: assert property (@(posedge sys_clk) disable iff (rst)
		(ingIn[2].valid && halfIs10g[1] && !ingIn[0].valid && !ingIn[1].valid) |=> ingChan[2].valid)
		else $error("10G port 2 not on channel 2");
	a_ten_three: assert property (@(posedge sys_clk) disable iff (rst)
		(ingIn[3].valid && halfIs10g[1] && !ingIn[0].valid && !ingIn[1].valid && !ingIn[2].valid)
		|=> ingChan[3].valid)
		else $error("10G port 3 not on channel 3");
	a_sel_default: assert property (@(posedge sys_clk)
		rst |-> activeSel[0] == PFD_HSEL_RESET && activeSel[3] == PFD_HSEL_RESET)
		else $error("hash selection not ip pair in reset");
	a_sel_follow: assert property (@(posedge sys_clk) disable iff (rst)
		1'b1 |=> activeSel == $past(hashSel))
		else $error("per port hash selection not taken");
	a_ing_idle: assert property (@(posedge sys_clk) disable iff (rst)
		ingIn == '0 |=> ingChan == '0)
		else $error("ingress channel busy with no input");
	a_crypt_on: assert property (@(posedge sys_clk) disable iff (rst)
		(macsecEnable && ingIn[0].valid) |=> cryptApplied[0])
		else $error("protection not applied while enabled");

	// aggregation checks
	a_lag_zero: assert property (@(posedge sys_clk) disable iff (rst)
		lagMembers == '0 |=> !lagAccept)
		else $error("empty group accepted");
	a_lag_four: assert property (@(posedge sys_clk) disable iff (rst)
		(lagIsFortyG && lagMembers == LAG_COUNT_W'(PFD_MAX_LAG_40G)) |=> lagAccept)
		else $error("40G group of four refused");
	a_lag_over: assert property (@(posedge sys_clk) disable iff (rst)
		(!lagIsFortyG && lagMembers > LAG_COUNT_W'(PFD_MAX_LAG_10G)) |=> !lagAccept)
		else $error("10G group over eight accepted");

	// egress checks
	a_egr_ten: assert property (@(posedge sys_clk) disable iff (rst)
		(cur.valid && halfIs10g[1] && cur.destPort == 2'h3) |=> egrPort[3].valid)
		else $error("10G egress beat not on its port");
	a_egr_data: assert property (@(posedge sys_clk) disable iff (rst)
		(cur.valid && halfIs10g[0] && cur.destPort == 2'h0) |=> egrPort[0].data == $past(cur.data))
		else $error("10G egress data altered");
	a_egr_forty: assert property (@(posedge sys_clk) disable iff (rst)
		(cur.valid && !halfIs10g[1] && cur.destPort[1]) |=> egrPort[2].valid && !egrPort[3].valid)
		else $error("40G egress beat not merged to one port");
	a_egr_idle: assert property (@(posedge sys_clk) disable iff (rst)
		!cur.valid |=> egrPort == '0)
		else $error("egress port busy with nothing taken");
	a_ready_swap: assert property (@(posedge sys_clk) disable iff (rst)
		(cur.valid && cur.eof) |=> egrReady != $past(egrReady))
		else $error("grant kept after end of frame");
	a_locked_keep: assert property (@(posedge sys_clk) disable iff (rst)
		(ownerLocked && !cur.valid) |=> egrReady == $past(egrReady))
		else $error("grant moved inside a frame");
	a_unit_hold: assert property (@(posedge sys_clk) disable iff (rst)
		!cur.valid |=> unitOut == $past(unitOut))
		else $error("unit select moved with nothing taken");
endmodule : pfd_port_flow_distributor

/* File: test/pfd_engine_model.sv */
module pfd_engine_model
	import pfd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic go,
	input wire logic [1:0] dest,
	input wire logic unit,
	input wire logic ready,
	output pfd_egr_beat_type beat
);
	timeunit 1ns;
	timeprecision 1ps;
	initial beat = '0;
	// holds each beat until the merger shows it taken, then drops valid
	always @(posedge sys_clk) begin
		if (ready && beat.valid) begin
			beat.valid <= 1'b0;
			beat.data <= ~beat.data;
		end else if (go && !beat.valid) begin
			beat <= '{1'b1, 1'b1, 1'b1, 64'hA5A5, dest, unit};
		end
	end
endmodule : pfd_engine_model

/* File: test/port_flow_distributor_tb.sv */
module port_flow_distributor_tb;
	import pfd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
	int errors = 0;
	int num_checks = 0;
	logic sys_clk = 0;
	logic rst = 1;
	logic [1:0] halfIs10g = '0;
	pfd_hsel_type [3:0] hashSel = '0;
	logic macsecEnable = 0;
	pfd_ing_beat_type [3:0] ingIn = '0;
	pfd_egr_beat_type [1:0] egrIn;
	logic [3:0] lagMembers = '0;
	logic lagIsFortyG = 0;
	pfd_ing_beat_type [3:0] ingChan;
	pfd_egr_beat_type [3:0] egrPort;
	logic [1:0] egrReady;
	logic [3:0] cryptApplied;
	logic unitOut;
	logic lagAccept;
	logic [1:0] go = '0;
	logic [1:0] dest = '0;
	logic unit = 0;
	initial forever #2.5 sys_clk = ~sys_clk;
	pfd_port_flow_distributor #(.LAG_COUNT_W(4)) i_dut (.sys_clk(sys_clk), .rst(rst),
		.halfIs10g(halfIs10g), .hashSel(hashSel), .macsecEnable(macsecEnable),
		.ingIn(ingIn), .egrIn(egrIn), .lagMembers(lagMembers), .lagIsFortyG(lagIsFortyG),
		.ingChan(ingChan), .egrPort(egrPort), .egrReady(egrReady),
		.cryptApplied(cryptApplied), .unitOut(unitOut), .lagAccept(lagAccept));
	for (genvar e = 0; e < 2; e++) begin : g_eng
		pfd_engine_model i_eng (.sys_clk(sys_clk), .go(go[e]), .dest(dest), .unit(unit),
			.ready(egrReady[e]), .beat(egrIn[e]));
	end
	task automatic give_verdict;
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	task automatic send(input int p, input pfd_flow_key_type k);
		@(posedge sys_clk);
		ingIn[p] <= '{1'b1, 1'b1, 1'b1, 64'hC0DE, k};
		@(posedge sys_clk);
		ingIn[p] <= '0;
		#1;
	endtask : send
	function automatic logic [3:0] chv();
		for (int i = 0; i < 4; i++) chv[i] = ingChan[i].valid;
	endfunction : chv
	task automatic t_lag;
		for (int f = 0; f < 2; f++) for (int n = 0; n < 10; n++) begin
			@(posedge sys_clk);
			lagIsFortyG <= f[0];
			lagMembers <= n[3:0];
			@(posedge sys_clk);
			#1 `CHK(lagAccept, 1'(n >= 1 && n <= (f ? 4 : 8)))
		end
		$display("lag done");
	endtask : t_lag
	task automatic t_crypt;
		for (int e = 0; e < 2; e++) begin
			@(posedge sys_clk);
			macsecEnable <= ~e[0];
			for (int p = 0; p < 4; p++) ingIn[p] <= '{1'b1, 1'b1, 1'b1, 64'hC0DE, '0};
			@(posedge sys_clk);
			ingIn <= '0;
			#1 `CHK(cryptApplied, {4{~e[0]}})
		end
		$display("crypt done");
	endtask : t_crypt
	task automatic t_10g;
		@(posedge sys_clk);
		halfIs10g <= 2'b11;
		for (int p = 0; p < 4; p++) begin
			send(p, '0);
			`CHK(chv(), 4'(1 << p))
			`CHK(ingChan[p].data, 64'hC0DE)
		end
		$display("ingress 10g done");
	endtask : t_10g
	task automatic t_40g;
		logic [3:0] first;
		@(posedge sys_clk);
		halfIs10g <= 2'b00;
		send(1, '{48'h1, 48'h2, 32'hA, 32'hB, 16'h50, 16'h51, 8'h6});
		first = chv();
		`CHK($countones(first), 1)
		send(1, '{48'h1, 48'h2, 32'hA, 32'hB, 16'h50, 16'h51, 8'h6});
		`CHK(chv(), first)
		$display("ingress 40g done");
	endtask : t_40g
	task automatic t_egr(input int e, input logic is10g, input logic [1:0] d, input int port,
			input logic u);
		int i;
		@(posedge sys_clk);
		halfIs10g <= {2{is10g}};
		dest <= d;
		unit <= u;
		go[e] <= 1'b1;
		@(posedge sys_clk);
		go[e] <= 1'b0;
		for (i = 0; i < 20 && egrPort[port].valid !== 1'b1; i++) @(posedge sys_clk) #1;
		`CHK(egrPort[port].valid, 1'b1)
		`CHK(unitOut, u)
		@(posedge sys_clk) #1;
		`CHK(egrPort[port].valid, 1'b0)
		`CHK(egrIn[e].valid, 1'b0)
		$display("egress done");
	endtask : t_egr
	initial begin
		#5000;
		errors++;
		give_verdict();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		t_lag();
		t_crypt();
		t_10g();
		t_40g();
		t_egr(0, 1'b1, 2'h2, 2, 1'b1);
		t_egr(1, 1'b0, 2'h3, 2, 1'b0);
		give_verdict();
	end
endmodule : port_flow_distributor_tb
